/* rtl/cwsu_pkg.sv */
// Package: register map, field layout and types for the complementary wave generator
package cwsu_pkg;

    localparam logic [3:0] ADDR_CTRL0     = 4'h0;
    localparam logic [3:0] ADDR_CTRL1     = 4'h1;
    localparam logic [3:0] ADDR_INSEL     = 4'h2;
    localparam logic [3:0] ADDR_SHUTCTRL0 = 4'h3;
    localparam logic [3:0] ADDR_AUTOSHUT0 = 4'h4;
    localparam logic [3:0] ADDR_AUTOSHUT1 = 4'h5;
    localparam logic [3:0] ADDR_DBRISE    = 4'h6;
    localparam logic [3:0] ADDR_DBFALL    = 4'h7;
    localparam logic [3:0] ADDR_CLKSEL    = 4'h8;
    localparam logic [3:0] ADDR_STEER     = 4'h9;

    localparam int CTRL0_EN_BIT    = 7;
    localparam int AUTOSHUT0_SD    = 7;
    localparam int AUTOSHUT0_REN   = 6;
    localparam int DB_WIDTH        = 6;
    localparam int NUM_OUT         = 4;
    localparam int NUM_SRC         = 16;
    localparam int NUM_SD_SRC      = 8;

    localparam logic [2:0] MODE_STEER_SYNC = 3'h0;
    localparam logic [2:0] MODE_STEER_ASYN = 3'h1;
    localparam logic [2:0] MODE_HALF       = 3'h4;
    localparam logic [2:0] MODE_PUSHPULL   = 3'h5;

    localparam logic [1:0] LVL_INACTIVE = 2'h0;
    localparam logic [1:0] LVL_TRISTATE = 2'h1;
    localparam logic [1:0] LVL_LOW      = 2'h2;
    localparam logic [1:0] LVL_HIGH     = 2'h3;

    localparam logic [7:0] RESET_SHUTCTRL0 = 8'h14;
    localparam logic [7:0] RESET_AUTOSHUT0 = 8'h00;
    localparam logic [7:0] RESET_ZERO      = 8'h00;

    typedef struct packed {
        logic [31:0] dat;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic        we;
        logic        stb;
        logic        cyc;
    } cwsu_wb_req_type;

    typedef struct packed {
        logic [NUM_OUT-1:0] level;
        logic [NUM_OUT-1:0] drive;
    } cwsu_out_type;

endpackage : cwsu_pkg

/* rtl/cwsu_deadband.sv */
// Dead-band delay for one output edge pair
`timescale 1ns/1ps
module cwsu_deadband
    import cwsu_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                enable,
    input  wire logic                din,
    input  wire logic [DB_WIDTH-1:0] riseCount,
    input  wire logic [DB_WIDTH-1:0] fallCount,
    output logic                     dout
);

    logic [DB_WIDTH-1:0] count;
    logic                target;

    // Each edge is held back by its programmed count; an input that
    // reverts before the count expires is swallowed, so no glitch passes.
    always_ff @(posedge clk)
    begin
        if (!rst_b || !enable)
        begin
            dout   <= 1'b0;
            count  <= '0;
            target <= 1'b0;
        end
        else if (din == dout)
        begin
            target <= din;
            count  <= '0;
        end
        else if (din != target)
        begin
            target <= din;
            count  <= '0;
            if ((din ? riseCount : fallCount) == '0)
                dout <= din;
        end
        else if (count + 1'b1 >= (din ? riseCount : fallCount))
        begin
            dout  <= din;
            count <= '0;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

endmodule : cwsu_deadband

/* rtl/cwsu_top.sv */
// Complementary waveform generator: registers, shutdown, steering, dead band
//
// Contract
// [R1] Generator runs on its own selected clock; code only samples its rising edge, dead band and toggle run on the bus clock
// [R2] Fast oscillator kept alive when needed in sleep
// [R3] Sleep idles processor only, generation continues
// [R4] Software sets pins to input before setup
// [R5] Software clears enable before reconfiguring
// [R6] Three-bit mode field selects output mode
// [R7] Per-output polarity bits set output sense
// [R8] Four-bit field selects data input source
// [R9] Steering bits choose modulated outputs
// [R10] Pair override levels; start in shutdown
// [R11] Enable bits pick shutdown sources
// [R12] Separate rising and falling dead-band registers
// [R13] Clock control register selects generator clock
// [R14] Software enables, then makes pins outputs
// [R15] Auto-restart clears shutdown, else software does
// [R16] Shutdown forces pair override levels
// [R17] Edges delayed by dead-band counts
// [R18] Disable returns generator to reset state
`timescale 1ns/1ps
module cwsu_top
    import cwsu_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire cwsu_wb_req_type       wbReq,
    output logic [31:0]                wbDatO,
    output logic                       wbAck,
    input  wire logic [NUM_SRC-1:0]    srcIn,
    input  wire logic [NUM_SD_SRC-1:0] shutSrcIn,
    input  wire logic [1:0]            genClkIn,
    input  wire logic                  sleepReq,
    output cwsu_out_type               waveOut,
    output logic                       fastOscKeep,
    output logic                       cpuIdle
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] waveCtrlReg0;
    logic [7:0] waveCtrlReg1;
    logic [7:0] waveInputSelectReg;
    logic [7:0] waveShutdownCtrl0;
    logic [7:0] waveAutoshutReg0;
    logic [7:0] waveAutoshutReg1;
    logic [7:0] riseDeadbandReg;
    logic [7:0] fallDeadbandReg;
    logic [7:0] waveClockSelectReg;
    logic [7:0] steeringOutputBits;

    logic       moduleEnable;
    logic       shutdownSet;
    logic       shutdownStatus;
    logic       wbHit;
    logic       wbWrite;
    logic       swClearShutdown;
    logic [7:0] wbByte;
    logic [31:0] next_wbDatO;

    assign moduleEnable    = waveCtrlReg0[CTRL0_EN_BIT];
    assign wbHit           = wbReq.cyc && wbReq.stb && !wbAck;
    assign wbWrite         = wbHit && wbReq.we && wbReq.sel[0];
    assign wbByte          = wbReq.dat[7:0];
    assign shutdownStatus  = waveAutoshutReg0[AUTOSHUT0_SD];
    assign swClearShutdown = wbWrite && (wbReq.adr == ADDR_AUTOSHUT0)
                             && !wbByte[AUTOSHUT0_SD];

    // Ack one cycle after the strobe, drop it the cycle after
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wbAck <= 1'b0;
        else
            wbAck <= wbHit;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            waveCtrlReg0       <= RESET_ZERO;
            waveCtrlReg1       <= RESET_ZERO;
            waveInputSelectReg <= RESET_ZERO;
            waveShutdownCtrl0  <= RESET_SHUTCTRL0;
            waveAutoshutReg1   <= RESET_ZERO;
            riseDeadbandReg    <= RESET_ZERO;
            fallDeadbandReg    <= RESET_ZERO;
            waveClockSelectReg <= RESET_ZERO;
            steeringOutputBits <= RESET_ZERO;
        end
        else if (wbWrite)
        begin
            case (wbReq.adr)
                ADDR_CTRL0:     waveCtrlReg0       <= wbByte; // R6
                ADDR_CTRL1:     waveCtrlReg1       <= wbByte; // R7
                ADDR_INSEL:     waveInputSelectReg <= wbByte; // R8
                ADDR_SHUTCTRL0: waveShutdownCtrl0  <= wbByte; // R10
                ADDR_AUTOSHUT1: waveAutoshutReg1   <= wbByte; // R11
                ADDR_DBRISE:    riseDeadbandReg    <= wbByte; // R12
                ADDR_DBFALL:    fallDeadbandReg    <= wbByte; // R12
                ADDR_CLKSEL:    waveClockSelectReg <= wbByte; // R13
                ADDR_STEER:     steeringOutputBits <= wbByte; // R9
                default:        ;
            endcase
        end
    end

    always_comb
    begin
        next_wbDatO = '0;
        case (wbReq.adr)
            ADDR_CTRL0:     next_wbDatO[7:0] = waveCtrlReg0;
            ADDR_CTRL1:     next_wbDatO[7:0] = waveCtrlReg1;
            ADDR_INSEL:     next_wbDatO[7:0] = waveInputSelectReg;
            ADDR_SHUTCTRL0: next_wbDatO[7:0] = waveShutdownCtrl0;
            ADDR_AUTOSHUT0: next_wbDatO[7:0] = waveAutoshutReg0;
            ADDR_AUTOSHUT1: next_wbDatO[7:0] = waveAutoshutReg1;
            ADDR_DBRISE:    next_wbDatO[7:0] = riseDeadbandReg;
            ADDR_DBFALL:    next_wbDatO[7:0] = fallDeadbandReg;
            ADDR_CLKSEL:    next_wbDatO[7:0] = waveClockSelectReg;
            ADDR_STEER:     next_wbDatO[7:0] = steeringOutputBits;
            default:        next_wbDatO = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wbDatO <= '0;
        else if (wbHit)
            wbDatO <= next_wbDatO;
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [NUM_SRC-1:0]    srcMeta;
    logic [NUM_SRC-1:0]    srcSync;
    logic [NUM_SD_SRC-1:0] sdMeta;
    logic [NUM_SD_SRC-1:0] sdSync;
    logic [1:0]            clkMeta;
    logic [1:0]            clkSync;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            srcMeta <= '0;
            srcSync <= '0;
            sdMeta  <= '0;
            sdSync  <= '0;
            clkMeta <= '0;
            clkSync <= '0;
        end
        else
        begin
            srcMeta <= srcIn;
            srcSync <= srcMeta;
            sdMeta  <= shutSrcIn;
            sdSync  <= sdMeta;
            clkMeta <= genClkIn;
            clkSync <= clkMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Generator clock tick and data source

    logic genClkPrev;
    logic genTick;
    logic genClkSel;
    logic dataIn;

    // Generator clock is one of two sampled sources; its rising edge times the
    // auto-restart clear and holds the toggle when data is high; dead band and toggle run on the bus clock.
    assign genClkSel = clkSync[waveClockSelectReg[0]]; // R13
    assign genTick   = genClkSel && !genClkPrev; // R1
    assign dataIn    = srcSync[waveInputSelectReg[3:0]]; // R8

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            genClkPrev <= 1'b0;
        else
            genClkPrev <= genClkSel;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shutdown status

    logic shutEvent;

    assign shutEvent = |(sdSync & waveAutoshutReg1[NUM_SD_SRC-1:0]); // R11

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            waveAutoshutReg0 <= RESET_AUTOSHUT0;
        else if (!moduleEnable)
        begin
            // Disabled generator always restarts from shutdown
            waveAutoshutReg0[AUTOSHUT0_SD] <= 1'b1; // R10 R18
            if (wbWrite && wbReq.adr == ADDR_AUTOSHUT0)
                waveAutoshutReg0[AUTOSHUT0_REN] <= wbByte[AUTOSHUT0_REN];
        end
        else
        begin
            if (wbWrite && wbReq.adr == ADDR_AUTOSHUT0)
                waveAutoshutReg0[AUTOSHUT0_REN] <= wbByte[AUTOSHUT0_REN];
            // A live shutdown source wins over any clear
            if (shutEvent)
                waveAutoshutReg0[AUTOSHUT0_SD] <= 1'b1;
            else if (waveAutoshutReg0[AUTOSHUT0_REN] && genTick)
                waveAutoshutReg0[AUTOSHUT0_SD] <= 1'b0; // R15
            else if (swClearShutdown)
                waveAutoshutReg0[AUTOSHUT0_SD] <= 1'b0; // R15
        end
    end

    assign shutdownSet = shutdownStatus;

    ////////////////////////////////////////////////////////////////////////
    // Mode and steering

    logic [2:0]         mode;
    logic [NUM_OUT-1:0] rawWave;
    logic               toggle;

    assign mode = waveCtrlReg0[2:0]; // R6

    always_ff @(posedge clk)
    begin
        if (!rst_b || !moduleEnable)
            toggle <= 1'b0; // R18
        else if (genTick && dataIn && !genClkPrev)
            toggle <= toggle;
        else if (dataIn && !rawWave[0] && !rawWave[1])
            toggle <= !toggle;
    end

    always_comb
    begin
        rawWave = '0;
        case (mode)
            MODE_STEER_SYNC,
            MODE_STEER_ASYN: rawWave = {NUM_OUT{dataIn}} & steeringOutputBits[NUM_OUT-1:0]; // R9
            MODE_HALF:       rawWave = {!dataIn, dataIn, !dataIn, dataIn};
            MODE_PUSHPULL:   rawWave = {!toggle & dataIn, toggle & dataIn,
                                        !toggle & dataIn, toggle & dataIn};
            default:         rawWave = {!dataIn, dataIn, !dataIn, dataIn};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Dead band per output

    logic [NUM_OUT-1:0] delayed;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1)
        begin : g_db
            cwsu_deadband u_db
            (
                .clk       (clk),
                .rst_b     (rst_b),
                .enable    (moduleEnable),
                .din       (rawWave[gi]),
                .riseCount (riseDeadbandReg[DB_WIDTH-1:0]),
                .fallCount (fallDeadbandReg[DB_WIDTH-1:0]),
                .dout      (delayed[gi])
            ); // R17
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output stage

    cwsu_out_type next_waveOut;
    logic [1:0]   lvl;
    integer       k;

    always_comb
    begin
        next_waveOut = '0;
        lvl          = LVL_INACTIVE;
        for (k = 0; k < NUM_OUT; k = k + 1)
        begin
            // A and C are even outputs, B and D odd
            lvl = k[0] ? waveShutdownCtrl0[5:4] : waveShutdownCtrl0[3:2];
            if (!moduleEnable)
            begin
                next_waveOut.level[k] = waveCtrlReg1[k]; // R18
                next_waveOut.drive[k] = 1'b0;
            end
            else if (shutdownSet)
            begin
                next_waveOut.drive[k] = (lvl != LVL_TRISTATE); // R16
                case (lvl)
                    LVL_LOW:  next_waveOut.level[k] = 1'b0;
                    LVL_HIGH: next_waveOut.level[k] = 1'b1;
                    default:  next_waveOut.level[k] = waveCtrlReg1[k];
                endcase
            end
            else
            begin
                next_waveOut.drive[k] = 1'b1;
                next_waveOut.level[k] = delayed[k] ^ waveCtrlReg1[k]; // R7
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            waveOut <= '0;
        else
            waveOut <= next_waveOut;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep support

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fastOscKeep <= 1'b0;
            cpuIdle     <= 1'b0;
        end
        else
        begin
            // Oscillator held while the generator needs it, else sleep saves power
            fastOscKeep <= moduleEnable && (|srcSync) && !waveClockSelectReg[0]; // R2
            cpuIdle     <= sleepReq; // R3
        end
    end

endmodule : cwsu_top

/* tb/cwsu_top_sva.sv */
// Concurrent checks on the generator's ports
`timescale 1ns/1ps
module cwsu_top_sva
    import cwsu_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input wire cwsu_wb_req_type wbReq,
    input wire logic [31:0]     wbDatO,
    input wire logic            wbAck,
    input wire logic            sleepReq,
    input wire cwsu_out_type    waveOut,
    input wire logic            fastOscKeep,
    input wire logic            cpuIdle
);
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic taken;
    logic enReg;

    assign taken = wbReq.cyc && wbReq.stb && !wbAck;

    // Shadow of the enable bit, rebuilt from bus writes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            enReg <= 1'h0;
        else if (taken && wbReq.we && wbReq.sel[0] && wbReq.adr == ADDR_CTRL0)
            enReg <= wbReq.dat[CTRL0_EN_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        taken;
    endsequence
    // Three samples off leave time for the registered outputs to follow
    sequence s_off;
        !enReg [*3];
    endsequence

    property p_ack;
        s_take |=> wbAck;
    endproperty
    property p_ack_once;
        wbAck |=> !wbAck;
    endproperty
    property p_idle;
        !(wbReq.cyc && wbReq.stb) |=> !wbAck;
    endproperty
    property p_upper;
        wbAck |-> wbDatO[31:8] == 24'h0;
    endproperty
    property p_unmap;
        s_take ##0 (!wbReq.we && wbReq.adr > ADDR_STEER) |=> wbDatO == 32'h0;
    endproperty
    property p_off_drive;
        s_off |-> waveOut.drive == 4'h0;
    endproperty
    property p_off_osc;
        s_off |-> !fastOscKeep;
    endproperty
    property p_osc_en;
        fastOscKeep |-> (enReg || $past(enReg));
    endproperty
    property p_sleep;
        $rose(sleepReq) |=> cpuIdle;
    endproperty

    a_ack: assert property (p_ack)
        else $error("request not acknowledged");
    a_ack_once: assert property (p_ack_once)
        else $error("acknowledge longer than one cycle");
    a_idle: assert property (p_idle)
        else $error("acknowledge without request");
    a_upper: assert property (p_upper)
        else $error("upper read data not zero");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_off_drive: assert property (p_off_drive)
        else $error("outputs driven while disabled");
    a_off_osc: assert property (p_off_osc)
        else $error("oscillator kept while disabled");
    a_osc_en: assert property (p_osc_en)
        else $error("oscillator kept without enable");
    a_sleep: assert property (p_sleep)
        else $error("processor not idled on sleep");
endmodule : cwsu_top_sva

bind cwsu_top cwsu_top_sva cwsu_top_sva_inst
(
    .clk         (clk),
    .rst_b       (rst_b),
    .wbReq       (wbReq),
    .wbDatO      (wbDatO),
    .wbAck       (wbAck),
    .sleepReq    (sleepReq),
    .waveOut     (waveOut),
    .fastOscKeep (fastOscKeep),
    .cpuIdle     (cpuIdle)
);

/* tb/cwsu_switch_stage.sv */
// Model of the external power stage on the generator pins
`timescale 1ns/1ps
module cwsu_switch_stage
    import cwsu_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          watch,
    input  wire cwsu_out_type  waveOut,
    output logic [NUM_OUT-1:0] pinLevel,
    output logic [7:0]         shootCount
);
    // Released pins sit on board pull-downs, a safe level for the switches
    assign pinLevel = waveOut.level & waveOut.drive;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            shootCount <= 8'h00;
        else if (watch && ((pinLevel[0] && pinLevel[1]) || (pinLevel[2] && pinLevel[3])))
            shootCount <= shootCount + 8'h01;
    end
endmodule : cwsu_switch_stage

/* tb/cwsu_top_bench.sv */
// Self-checking bench for the complementary wave generator
`timescale 1ns/1ps
module cwsu_top_bench
    import cwsu_pkg::*;
;
    localparam logic [7:0] MSK [10] = '{8'h07, 8'h0F, 8'h0F, 8'h3C, 8'h40,
                                        8'hFF, 8'h3F, 8'h3F, 8'h01, 8'h0F};
    logic                  clk;
    logic                  rst_b;
    cwsu_wb_req_type       wbReq;
    logic [31:0]           wbDatO;
    logic                  wbAck;
    logic [NUM_SRC-1:0]    srcIn;
    logic [NUM_SD_SRC-1:0] shutSrcIn;
    logic [1:0]            genClkIn = 2'h0;
    logic                  sleepReq;
    cwsu_out_type          waveOut;
    logic                  fastOscKeep;
    logic                  cpuIdle;
    logic [NUM_OUT-1:0]    pinLevel;
    logic [7:0]            shootCount;
    logic                  watch;
    int                    fails;
    int                    samplesChecked;
    logic [31:0]           rnd;
    logic [3:0]            sIdx;
    logic [7:0]            q;

    cwsu_top cwsu_top_inst (.clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbDatO(wbDatO),
        .wbAck(wbAck), .srcIn(srcIn), .shutSrcIn(shutSrcIn), .genClkIn(genClkIn),
        .sleepReq(sleepReq), .waveOut(waveOut), .fastOscKeep(fastOscKeep), .cpuIdle(cpuIdle));
    cwsu_switch_stage cwsu_switch_stage_inst (.clk(clk), .rst_b(rst_b), .watch(watch),
        .waveOut(waveOut), .pinLevel(pinLevel), .shootCount(shootCount));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Two free-running generator clocks at half and quarter rate
    always @(posedge clk) genClkIn <= genClkIn + 2'h1;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] follow(input logic b, input logic [3:0] pol);
        return {{4{b}} ^ pol, 4'hF};
    endfunction : follow

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            fails++;
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] rq);
        int n;
        @(posedge clk);
        wbReq <= '{dat: {24'h0, d}, adr: a, sel: s, we: w, stb: 1'h1, cyc: 1'h1};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wbAck !== 1'h1 && n < 20);
        rq = wbDatO[7:0];
        wbReq <= '0;
        if (n >= 20)
            fails++;
    endtask : wb
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] x;
        wb(a, 1'h1, d, 4'h1, x);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] rq);
        wb(a, 1'h0, 8'h00, 4'hF, rq);
    endtask : rd
    // Configuration always starts from the disabled state
    task automatic setup(input logic [2:0] md, input logic [3:0] pol, input logic ren,
                         input logic [7:0] cks, input logic [5:0] db);
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, {4'h0, pol});
        wr(ADDR_INSEL, {4'h0, sIdx});
        wr(ADDR_SHUTCTRL0, {2'h0, LVL_HIGH, LVL_LOW, 2'h0});
        wr(ADDR_AUTOSHUT0, {1'h0, ren, 6'h0});
        wr(ADDR_AUTOSHUT1, 8'h01 << sIdx[2:0]);
        wr(ADDR_DBRISE, {2'h0, db});
        wr(ADDR_DBFALL, {2'h0, db});
        wr(ADDR_CLKSEL, cks);
        wr(ADDR_STEER, 8'h0F);
        wr(ADDR_CTRL0, {1'h1, 4'h0, md});
    endtask : setup

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'h0;
        wbReq = '0;
        srcIn = '0;
        shutSrcIn = '0;
        sleepReq = 1'h0;
        watch = 1'h0;
        fails = 0;
        samplesChecked = 0;
        rnd = 32'hC408;
        sIdx = 4'h0;
        tick(2);
        rst_b <= 1'h1;
        for (int i = 0; i < 16; i++)
        begin
            rd(i[3:0], q);
            check("reset", (i == 3) ? RESET_SHUTCTRL0 : (i == 4) ? 8'h80 : RESET_ZERO, q);
        end
        for (int r = 0; r < 4; r++)
            for (int i = 0; i < 10; i++)
            begin
                rnd = lfsr(rnd);
                wr(i[3:0], rnd[7:0] & MSK[i]);
                rd(i[3:0], q);
                check("readback", rnd[7:0] & MSK[i], q & MSK[i]);
            end
        wr(ADDR_CTRL1, 8'h05);
        wb(ADDR_CTRL1, 1'h1, 8'h0A, 4'h0, q);
        rd(ADDR_CTRL1, q);
        check("byte select", 8'h05, q);
        wr(4'hC, 8'hFF);
        rd(4'hC, q);
        check("unmapped", 8'h00, q);
        tick(3);
        check("disabled", 8'h50, waveOut);
        // Without auto-restart the shutdown state must persist
        rnd = lfsr(rnd);
        sIdx = rnd[3:0];
        setup(MODE_STEER_ASYN, 4'h0, 1'h0, 8'h00, 6'h0);
        tick(6);
        check("override", 8'hAF, waveOut);
        tick(20);
        rd(ADDR_AUTOSHUT0, q);
        check("no restart", 8'h80, q & 8'h80);
        wr(ADDR_AUTOSHUT0, 8'h00);
        for (int b = 1; b >= 0; b--)
        begin
            srcIn[sIdx] <= b[0];
            sleepReq <= b[0];
            tick(10);
            check("steer", follow(b[0], 4'h0), waveOut);
            check("idle", {7'h0, b[0]}, {7'h0, cpuIdle});
            check("osc keep", {7'h0, b[0]}, {7'h0, fastOscKeep});
        end
        for (int m = 0; m < 2; m++)
        begin
            rnd = lfsr(rnd);
            sIdx = rnd[3:0];
            setup(m[2:0], rnd[7:4], 1'h1, 8'h00, 6'h0);
            srcIn[sIdx] <= 1'h1;
            tick(12);
            rd(ADDR_AUTOSHUT0, q);
            check("restart", 8'h00, q & 8'h80);
            check("polarity", follow(1'h1, rnd[7:4]), waveOut);
            shutSrcIn[sIdx[2:0] + 3'h1] <= 1'h1;
            tick(8);
            check("masked source", follow(1'h1, rnd[7:4]), waveOut);
            shutSrcIn <= 8'h01 << sIdx[2:0];
            tick(8);
            rd(ADDR_AUTOSHUT0, q);
            check("auto shutdown", 8'h80, q & 8'h80);
            check("forced drive", 8'h0F, {4'h0, waveOut.drive});
            shutSrcIn <= '0;
            tick(12);
            check("resume", follow(1'h1, rnd[7:4]), waveOut);
            srcIn <= '0;
        end
        watch <= 1'h1;
        for (int m = 4; m < 6; m++)
        begin
            rnd = lfsr(rnd);
            sIdx = rnd[3:0];
            setup(m[2:0], 4'h0, 1'h1, 8'h01, rnd[13:8]);
            repeat (7)
            begin
                srcIn[sIdx] <= ~srcIn[sIdx];
                tick(90);
            end
            check("mode drive", 8'h0F, {4'h0, waveOut.drive});
            check("other clock", 8'h00, {7'h0, fastOscKeep});
            srcIn <= '0;
        end
        check("overlap", 8'h00, shootCount);
        wr(ADDR_CTRL0, 8'h00);
        tick(4);
        check("disable", 8'h00, waveOut);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : cwsu_top_bench
